/* File: spish_map.svh */
// Constants of the serial host port: link codes, command fields, register map.
// Assumes the includer has a 200 MHz system clock.
`ifndef SPISH_MAP_SVH
`define SPISH_MAP_SVH

// ****************************************
// Link codes
// ****************************************
`define SPISH_INIT0 8'h12
`define SPISH_INIT1 8'h4a
`define SPISH_INIT2 8'h5c
`define SPISH_OK 8'h58
`define SPISH_FAIL 8'h52
`define SPISH_BUSY 8'h54
`define SPISH_TOKEN 8'h55
`define SPISH_IDLE 8'h00

// ****************************************
// Command fields
// ****************************************
`define SPISH_TYPE 7:6
`define SPISH_TYPE_RW 2'b01
`define SPISH_WR 5
`define SPISH_MEM 4
`define SPISH_LONG 2
`define SPISH_SLEN 1:0
`define SPISH_GRAN 7:6
`define SPISH_GRAN8 2'b00
`define SPISH_GRAN32 2'b01
`define SPISH_LAST8 5'd7
`define SPISH_LAST32 5'd31
`define SPISH_CMD_LAST 4'd3
`define SPISH_ADR_LAST 4'd7
`define SPISH_INIT_LAST 4'd2

// ****************************************
// Timing
// ****************************************
`define SPISH_CLK_PS 5000
`define SPISH_SCLK_MIN_PS 12500
`define SPISH_HALF_MIN ((`SPISH_SCLK_MIN_PS / 2 + `SPISH_CLK_PS - 1) / `SPISH_CLK_PS)
`define SPISH_HALF 8'd8

// ****************************************
// Controller registers (word index = adr[3:2])
// ****************************************
`define SPISH_REG_CTRL 2'd0
`define SPISH_REG_TXD 2'd1
`define SPISH_REG_RXD 2'd2
`define SPISH_REG_STAT 2'd3
`define SPISH_CTRL_SEL 0
`define SPISH_CTRL_W32 1

`endif

/* File: spish_pkg.sv */
// Types shared by both ends of the serial host port.
// Assumes nothing of its surroundings.
package spish_pkg;

  // Phase of the device's transfer engine.
  typedef enum logic [2:0] {
    SPISH_P_CMD,
    SPISH_P_RESP,
    SPISH_P_WAIT,
    SPISH_P_TOK,
    SPISH_P_DATA
  } spish_phase_t;

endpackage : spish_pkg

/* File: spish_if.sv */
// Link between the host master end and the device slave end.
// Assumes the bench joins the two modports; output line reads low when undriven.
`timescale 1ns/1ps
interface spish_if;
  logic sclk;
  logic sel_n;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic miso_line;
  logic host_event_line;

  // Resolved level of the shared output data line.
  assign miso_line = miso_oe ? miso : 1'b0;

  modport dev (
    input  sclk,
    input  sel_n,
    input  mosi,
    output miso,
    output miso_oe,
    output host_event_line
  );

  modport host (
    output sclk,
    output sel_n,
    output mosi,
    input  miso_line,
    input  host_event_line
  );
endinterface : spish_if

/* File: spish_sync.sv */
// Two-flop synchroniser for a group of pins, with edge pulses for bit 0.
// Assumes every input is asynchronous to clk_i.
`timescale 1ns/1ps
module spish_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o,
  output logic              rise_o,
  output logic              fall_o
);
  logic [W-1:0] m_q;
  logic [W-1:0] s_q;
  logic         old_q;

  // One two-stage chain per bit.
  for (genvar i = 0; i < W; i++)
  begin : g_bit
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
      begin
        m_q[i] <= 1'b0;
        s_q[i] <= 1'b0;
      end
      else
      begin
        m_q[i] <= d_i[i];
        s_q[i] <= m_q[i];
      end
    end
  end

  // Edge finder looks only at the second stage.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      old_q <= 1'b0;
    else
      old_q <= s_q[0];
  end

  assign q_o    = s_q;
  assign rise_o = s_q[0] & ~old_q;
  assign fall_o = ~s_q[0] & old_q;
endmodule : spish_sync

/* File: spish_dev.sv */
// Device end: serial slave that decodes commands and answers with status codes.
// Assumes the host makes the serial clock well below a quarter of clk_i.
`timescale 1ns/1ps
`include "spish_map.svh"
module spish_dev
  import spish_pkg::*;
(
  input  wire logic   clk_i,
  input  wire logic   rst_i,
  spish_if.dev        link,
  input  wire logic   int_act_low_i,
  input  wire logic [3:0] event_i,
  input  wire logic   busy_i,
  input  wire logic   rd_valid_i,
  input  wire logic [31:0] rd_data_i,
  output logic        rd_take_o,
  output logic        cmd_valid_o,
  output logic [31:0] cmd_o,
  output logic [31:0] addr_o,
  output logic        wr_valid_o,
  output logic [31:0] wr_data_o,
  output logic        ready_o
);
  // ****************************************
  // Pin sampling
  // ****************************************
  logic [2:0]   pin_s;
  logic         rise;
  logic         fall;
  logic         sel_n_s;
  logic         mosi_s;

  // Serial clock on bit 0 for edges; select enters inverted so reset reads as idle.
  spish_sync #(.W(3)) u_sync (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .d_i    ({link.mosi, !link.sel_n, link.sclk}),
    .q_o    (pin_s),
    .rise_o (rise),
    .fall_o (fall)
  );
  assign sel_n_s = !pin_s[1];
  assign mosi_s  = pin_s[2];

  // ****************************************
  // Engine state
  // ****************************************
  spish_phase_t ph_q;
  logic [4:0]   bit_q;
  logic [3:0]   nb_q;
  logic [31:0]  sh_q;
  logic [31:0]  tx_q;
  logic [31:0]  cmd_q;
  logic [31:0]  adr_q;
  logic [15:0]  rem_q;
  logic         ok_q;
  logic         rd_q;
  logic         g32_q;
  logic         init_q;
  logic         evt_q;
  logic         oe_q;

  logic         wide;
  logic         last;
  logic [7:0]   rx_b;
  logic [31:0]  full_c;
  logic [7:0]   c1;
  logic         init_end;
  logic         cmd_end;
  logic [7:0]   code;
  logic [15:0]  len;
  logic [15:0]  step;

  // Place an 8-bit value at the top of an 8-bit unit so its MSB leaves first, or in the low byte of a 32-bit unit.
  function automatic logic [31:0] unit8(input logic [7:0] v, input logic w32);
    unit8 = w32 ? {24'h0, v} : {v, 24'h0};
  endfunction : unit8

  // Unit width and completion of the current unit.
  always_comb
  begin
    wide     = g32_q && (ph_q == SPISH_P_WAIT || ph_q == SPISH_P_TOK || ph_q == SPISH_P_DATA);
    last     = rise && !sel_n_s && (bit_q == (wide ? `SPISH_LAST32 : `SPISH_LAST8));
    rx_b     = {sh_q[6:0], mosi_s};
    full_c   = (nb_q == `SPISH_CMD_LAST) ? {cmd_q[23:0], rx_b} : cmd_q;
    c1       = full_c[31:24];
    step     = g32_q ? 16'd4 : 16'd1;
    init_end = (nb_q == `SPISH_INIT_LAST) && (cmd_q[15:0] == {`SPISH_INIT0, `SPISH_INIT1})
               && (rx_b == `SPISH_INIT2);
    cmd_end  = ((nb_q == `SPISH_CMD_LAST) && !c1[`SPISH_MEM]) || (nb_q == `SPISH_ADR_LAST);
    len      = c1[`SPISH_LONG] ? {full_c[7:0], full_c[15:8]} :
               ((c1[`SPISH_SLEN] == 2'b00) ? 16'd4 : {14'h0, c1[`SPISH_SLEN]});
    // Status code for the command or init sequence just completed.
    if (init_end)
      code = init_q ? `SPISH_FAIL : (busy_i ? `SPISH_BUSY : `SPISH_OK);
    else if (!init_q)
      code = `SPISH_FAIL;
    else if (c1[`SPISH_TYPE] != `SPISH_TYPE_RW || (full_c[23:22] != `SPISH_GRAN8 && full_c[23:22] != `SPISH_GRAN32))
      code = `SPISH_FAIL;
    else if (busy_i)
      code = `SPISH_BUSY;
    else
      code = `SPISH_OK;
  end

  // ****************************************
  // Transfer engine
  // ****************************************
  // Shifts in on rising edges and out on falling edges; select high aborts.
  always_ff @(posedge clk_i)
  begin
    cmd_valid_o <= 1'b0;
    wr_valid_o  <= 1'b0;
    rd_take_o   <= 1'b0;
    if (rst_i)
    begin
      ph_q   <= SPISH_P_CMD;
      bit_q  <= 5'd0;
      nb_q   <= 4'd0;
      sh_q   <= 32'h0;
      tx_q   <= 32'h0;
      cmd_q  <= 32'h0;
      adr_q  <= 32'h0;
      rem_q  <= 16'h0;
      ok_q   <= 1'b0;
      rd_q   <= 1'b0;
      g32_q  <= 1'b0;
      init_q <= 1'b0;
      cmd_o  <= 32'h0;
      addr_o <= 32'h0;
      wr_data_o <= 32'h0;
    end
    else if (sel_n_s)
    begin
      ph_q  <= SPISH_P_CMD;
      bit_q <= 5'd0;
      nb_q  <= 4'd0;
      tx_q  <= 32'h0;
    end
    else if (last)
    begin
      bit_q <= 5'd0;
      sh_q  <= {sh_q[30:0], mosi_s};
      unique case (ph_q)
        SPISH_P_CMD:
        begin
          nb_q <= nb_q + 4'd1;
          if (nb_q <= `SPISH_CMD_LAST)
            cmd_q <= {cmd_q[23:0], rx_b};
          else
            adr_q <= {adr_q[23:0], rx_b};
          if (init_end || cmd_end)
          begin
            ph_q  <= SPISH_P_RESP;
            tx_q  <= unit8(code, 1'b0);
            ok_q  <= !init_end && code == `SPISH_OK;
            rd_q  <= !c1[`SPISH_WR];
            g32_q <= full_c[23:22] == `SPISH_GRAN32;
            rem_q <= len;
            if (init_end && code == `SPISH_OK)
              init_q <= 1'b1;
            if (!init_end && code == `SPISH_OK)
            begin
              cmd_valid_o <= 1'b1;
              cmd_o       <= full_c;
              addr_o      <= (nb_q == `SPISH_ADR_LAST) ? {adr_q[23:0], rx_b} : 32'h0;
            end
          end
        end
        SPISH_P_RESP, SPISH_P_WAIT:
        begin
          if (!ok_q || rem_q == 16'h0)
          begin
            ph_q <= SPISH_P_CMD;
            nb_q <= 4'd0;
            tx_q <= 32'h0;
          end
          else if (!rd_q)
          begin
            ph_q <= SPISH_P_DATA;
            tx_q <= 32'h0;
          end
          else if (rd_valid_i)
          begin
            ph_q <= SPISH_P_TOK;
            tx_q <= unit8(`SPISH_TOKEN, g32_q);
          end
          else
          begin
            ph_q <= SPISH_P_WAIT;
            tx_q <= unit8(`SPISH_IDLE, g32_q);
          end
        end
        SPISH_P_TOK:
        begin
          ph_q      <= SPISH_P_DATA;
          tx_q      <= g32_q ? rd_data_i : unit8(rd_data_i[7:0], 1'b0);
          rd_take_o <= 1'b1;
        end
        SPISH_P_DATA:
        begin
          if (!rd_q)
          begin
            wr_valid_o <= 1'b1;
            wr_data_o  <= g32_q ? {sh_q[30:0], mosi_s} : {24'h0, rx_b};
          end
          if (rem_q <= step)
          begin
            ph_q <= SPISH_P_CMD;
            nb_q <= 4'd0;
            tx_q <= 32'h0;
          end
          else
          begin
            rem_q <= rem_q - step;
            if (rd_q)
            begin
              tx_q      <= g32_q ? rd_data_i : unit8(rd_data_i[7:0], 1'b0);
              rd_take_o <= 1'b1;
            end
          end
        end
      endcase
    end
    else if (rise)
    begin
      bit_q <= bit_q + 5'd1;
      sh_q  <= {sh_q[30:0], mosi_s};
    end
    else if (fall && bit_q != 5'd0)
      tx_q <= {tx_q[30:0], 1'b0};
  end

  // ****************************************
  // Pins and event line
  // ****************************************
  // Output driver is released whenever select is high.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      oe_q <= 1'b0;
    else
      oe_q <= !sel_n_s;
  end

  // Level event: any pending cause, inverted when active low is chosen.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      evt_q <= 1'b0;
    else
      evt_q <= (|event_i) ^ int_act_low_i;
  end

  assign link.miso            = tx_q[31];
  assign link.miso_oe         = oe_q;
  assign link.host_event_line = evt_q;
  assign ready_o              = init_q;
endmodule : spish_dev

/* File: spish_host.sv */
// Host end: serial master steered by software over classic Wishbone.
// Assumes one 32-bit Wishbone master on clk_i; software frames transactions.
`timescale 1ns/1ps
`include "spish_map.svh"
module spish_host
  import spish_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  spish_if.host            link,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o
);
  logic [1:0]  pin_s;
  logic [1:0]  ctrl_q;
  logic        busy_q;
  logic [7:0]  div_q;
  logic [5:0]  cnt_q;
  logic        sclk_q;
  logic        mosi_q;
  logic [31:0] sh_q;
  logic [31:0] rx_q;
  logic        req;
  logic        start;

  // Output data line and event line come from the far end's clock domain.
  spish_sync #(.W(2)) u_sync (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .d_i    ({link.host_event_line, link.miso_line}),
    .q_o    (pin_s),
    .rise_o (),
    .fall_o ()
  );

  assign req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign start = req && wb_we_i && wb_sel_i[0] && wb_adr_i[3:2] == `SPISH_REG_TXD && !busy_q;

  // ****************************************
  // Wishbone slave
  // ****************************************
  // Answer one cycle after the request; the transmit data word reads zero.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      ctrl_q   <= 2'b00;
    end
    else
    begin
      wb_ack_o <= req;
      if (req && wb_we_i && wb_sel_i[0] && wb_adr_i[3:2] == `SPISH_REG_CTRL)
        ctrl_q <= wb_dat_i[1:0];
      unique case (wb_adr_i[3:2])
        `SPISH_REG_CTRL: wb_dat_o <= {30'h0, ctrl_q};
        `SPISH_REG_RXD:  wb_dat_o <= ctrl_q[`SPISH_CTRL_W32] ? rx_q : {24'h0, rx_q[7:0]};
        `SPISH_REG_STAT: wb_dat_o <= {30'h0, pin_s[1], busy_q};
        default:         wb_dat_o <= 32'h0;
      endcase
    end
  end

  // ****************************************
  // Serial engine
  // ****************************************
  // Mode zero: data out before the rising edge, next bit after the falling one.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      busy_q <= 1'b0;
      div_q  <= 8'h0;
      cnt_q  <= 6'h0;
      sclk_q <= 1'b0;
      mosi_q <= 1'b0;
      sh_q   <= 32'h0;
      rx_q   <= 32'h0;
    end
    else if (start)
    begin
      busy_q <= 1'b1;
      div_q  <= 8'h0;
      cnt_q  <= 6'h0;
      sh_q   <= ctrl_q[`SPISH_CTRL_W32] ? wb_dat_i : {wb_dat_i[7:0], 24'h0};
      mosi_q <= ctrl_q[`SPISH_CTRL_W32] ? wb_dat_i[31] : wb_dat_i[7];
    end
    else if (busy_q)
    begin
      if (div_q == `SPISH_HALF - 8'd1)
      begin
        div_q  <= 8'h0;
        sclk_q <= !sclk_q;
        if (!sclk_q)
          rx_q <= {rx_q[30:0], pin_s[0]};
        else
        begin
          cnt_q  <= cnt_q + 6'd1;
          sh_q   <= {sh_q[30:0], 1'b0};
          mosi_q <= sh_q[30];
          if (cnt_q == {1'b0, (ctrl_q[`SPISH_CTRL_W32] ? `SPISH_LAST32 : `SPISH_LAST8)})
            busy_q <= 1'b0;
        end
      end
      else
        div_q <= div_q + 8'd1;
    end
  end

  assign link.sclk  = sclk_q;
  assign link.mosi  = mosi_q;
  assign link.sel_n = !ctrl_q[`SPISH_CTRL_SEL];
endmodule : spish_host

/* File: spish_checker.sv */
// Checker of the serial link between the host end and the device end.
// Assumes the bench top wires it beside the link interface, one clock domain.
`timescale 1ns/1ps
module spish_checker (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       sclk,
  input  wire logic       sel_n,
  input  wire logic       mosi,
  input  wire logic       miso,
  input  wire logic       miso_oe,
  input  wire logic       host_event_line,
  input  wire logic       int_act_low_i,
  input  wire logic [3:0] event_i
);
  // ********************
  // Link properties
  // ********************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Level the event line must show one cycle later.
  logic ev_want;
  assign ev_want = (|event_i) ^ int_act_low_i;

  // One high phase of the serial clock, eight system cycles long.
  sequence s_high;
    $rose(sclk) ##0 sclk [*8];
  endsequence

  a_sel_frame: assert property ($rose(sclk) |-> !sel_n)
    else $error("serial clock rose while deselected");
  a_clk_idle: assert property (sel_n |-> !sclk)
    else $error("serial clock not low while idle");
  a_clk_half: assert property (s_high |=> !sclk)
    else $error("serial clock high phase too long");
  a_mosi_hold: assert property ($rose(sclk) |-> $stable(mosi) [*8])
    else $error("host data changed while clock high");
  a_miso_hold: assert property ($rose(sclk) |-> $stable(miso) [*2])
    else $error("device data changed at the capture edge");
  a_oe_off: assert property (sel_n [*5] |-> !miso_oe)
    else $error("device drives its line while deselected");
  a_oe_on: assert property (!sel_n [*5] |-> miso_oe)
    else $error("device does not drive its line while selected");
  a_event_level: assert property (!$past(rst_i) |-> host_event_line == $past(ev_want))
    else $error("event line does not follow pending events");
endmodule : spish_checker

/* File: tb_top.sv */
// Bench top: host and device ends joined by the link, host driven over Wishbone.
// Assumes the design files and the link interface are compiled first.
`timescale 1ns/1ps
module tb_top;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, watch = 1'b0, ack, cmd_v, wr_v;
  logic        act_low = 1'b0, busy = 1'b0, rd_valid = 1'b0;
  logic [3:0]  adr = 4'h0, ev = 4'h0;
  logic [31:0] wdat = 32'h0, rd_data = 32'h0, seed = 32'h7568, m = 32'hff;
  logic [31:0] rdat, dat_o, cmd, wr_data, addr;
  logic        ready, take;
  logic [63:0] e, ec;
  logic [63:0] qr[$], qc[$];
  logic [31:0] qw[$];
  logic [7:0]  ini [3] = '{8'h54, 8'h58, 8'h52};
  logic [24:0] bad [4] = '{{16'h4100, 1'b1, 8'h54}, {16'ha100, 1'b0, 8'h52},
                           {16'h6180, 1'b0, 8'h52}, {16'he1c0, 1'b0, 8'h52}};
  int          n_errors = 0, checks_done = 0, n_take = 0;

  spish_if link ();
  spish_host u_spish_host (.clk_i(clk_i), .rst_i(rst_i), .link(link), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack));
  spish_dev u_spish_dev (.clk_i(clk_i), .rst_i(rst_i), .link(link), .int_act_low_i(act_low), .event_i(ev),
    .busy_i(busy), .rd_valid_i(rd_valid), .rd_data_i(rd_data), .rd_take_o(take), .cmd_valid_o(cmd_v), .cmd_o(cmd),
    .addr_o(addr), .wr_valid_o(wr_v), .wr_data_o(wr_data), .ready_o(ready));
  spish_checker u_spish_checker (.clk_i(clk_i), .rst_i(rst_i), .sclk(link.sclk), .sel_n(link.sel_n),
    .mosi(link.mosi), .miso(link.miso), .miso_oe(link.miso_oe), .host_event_line(link.host_event_line),
    .int_act_low_i(act_low), .event_i(ev));

  // 200 MHz system clock.
  always #2.5 clk_i = ~clk_i;

  // ********************
  // Helpers
  // ********************
  // Xorshift source of random values.
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // Counts one comparison and reports a mismatch.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // One classic Wishbone cycle; c marks a read whose result is checked.
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, input logic c);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    watch <= c;
    do
      @(posedge clk_i);
    while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    watch <= 1'b0;
  endtask : wb

  // Shifts one unit, waits for the end, and reads back the received unit.
  task automatic xf(input logic [31:0] v, input logic c, input logic [31:0] x);
    wb(1'b1, 4'h4, v, 1'b0);
    do
      wb(1'b0, 4'hc, 32'h0, 1'b0);
    while (rdat[0] !== 1'b0);
    if (c)
      qr.push_back({m, x});
    wb(1'b0, 4'h8, 32'h0, c);
  endtask : xf

  // Sends k header bytes, then one byte whose answer must be x.
  task automatic fr(input logic [63:0] b, input int k, input logic [7:0] x);
    for (int i = k - 1; i >= 0; i--)
      xf({24'h0, b[8*i+:8]}, 1'b0, 32'h0);
    xf(32'h0, 1'b1, {24'h0, x});
  endtask : fr

  // Sets select and unit width, then lets the device see the change.
  task automatic sl(input logic [1:0] c);
    wb(1'b1, 4'h0, {30'h0, c}, 1'b0);
    m = c[1] ? 32'hffffffff : 32'hff;
    repeat (8) @(posedge clk_i);
  endtask : sl

  // Expects the synced event line level in the status word.
  task automatic st(input logic x);
    repeat (6) @(posedge clk_i);
    qr.push_back({32'h2, 30'h0, x, 1'b0});
    wb(1'b0, 4'hc, 32'h0, 1'b1);
  endtask : st

  // Prints the counts and the verdict, then ends the run.
  task report_and_stop();
    $display("checks %0d, errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop

  // ********************
  // Monitor and sequence
  // ********************
  // Takes the oldest note whenever a result shows up and compares.
  always @(posedge clk_i)
  begin
    if (ack === 1'b1 && watch === 1'b1)
    begin
      e = qr.size() > 0 ? qr.pop_front() : 64'hx;
      chk(dat_o & e[63:32], e[31:0], "read");
    end
    if (wr_v === 1'b1)
      chk(wr_data & m, qw.size() > 0 ? qw.pop_front() : 32'hx, "write");
    if (cmd_v === 1'b1)
    begin
      ec = qc.size() > 0 ? qc.pop_front() : 64'hx;
      chk(cmd, ec[63:32], "command");
      chk(addr, ec[31:0], "address");
    end
    if (take === 1'b1)
      n_take++;
  end

  // Main sequence: refusals, setup, writes and reads in both widths, events.
  initial
  begin
    logic [31:0] r;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    sl(2'b01);
    fr(64'h41000000, 4, 8'h52);
    sl(2'b00);
    for (int i = 0; i < 3; i++)
    begin
      busy <= (i == 0);
      sl(2'b01);
      fr(64'h124a5c, 3, ini[i]);
      chk(ready, i > 0, "ready");
      sl(2'b00);
    end
    for (int i = 0; i < 4; i++)
    begin
      busy <= bad[i][8];
      sl(2'b01);
      fr({32'h0, bad[i][24:9], 16'h0}, 4, bad[i][7:0]);
      sl(2'b00);
    end
    r = rnd();
    sl(2'b01);
    qc.push_back({32'h61000000, 32'h0});
    fr(64'h61000000, 4, 8'h58);
    qw.push_back({24'h0, r[7:0]});
    xf({24'h0, r[7:0]}, 1'b0, 32'h0);
    sl(2'b00);
    rd_data <= rnd();
    rd_valid <= 1'b1;
    sl(2'b01);
    qc.push_back({32'h41000000, 32'h0});
    fr(64'h41000000, 4, 8'h58);
    xf(32'h0, 1'b1, 32'h55);
    xf(32'h0, 1'b1, rd_data & 32'hff);
    sl(2'b00);
    rd_valid <= 1'b0;
    sl(2'b01);
    qc.push_back({32'h44000200, 32'h0});
    fr(64'h44000200, 4, 8'h58);
    xf(32'h0, 1'b1, 32'h0);
    rd_valid <= 1'b1;
    xf(32'h0, 1'b1, 32'h0);
    for (int i = 0; i < 3; i++)
      xf(32'h0, 1'b1, i == 0 ? 32'h55 : rd_data & 32'hff);
    sl(2'b00);
    r = rnd();
    sl(2'b01);
    qc.push_back({32'h70400000, r});
    fr({32'h70400000, r}, 8, 8'h58);
    sl(2'b11);
    r = rnd();
    qw.push_back(r);
    xf(r, 1'b0, 32'h0);
    sl(2'b00);
    sl(2'b01);
    qc.push_back({32'h40400000, 32'h0});
    fr(64'h40400000, 4, 8'h58);
    sl(2'b11);
    xf(32'h0, 1'b1, 32'h55);
    xf(32'h0, 1'b1, rd_data);
    sl(2'b00);
    for (int k = 0; k < 4; k++)
    begin
      ev <= 4'b0001 << k;
      st(1'b1);
      ev <= 4'h0;
      st(1'b0);
    end
    act_low <= 1'b1;
    st(1'b1);
    ev <= 4'h4;
    st(1'b0);
    chk(n_take, 32'd4, "read takes");
    report_and_stop();
  end

  // Cuts a hang short well past the expected run length.
  initial
  begin
    repeat (60000) @(posedge clk_i);
    n_errors++;
    report_and_stop();
  end
endmodule : tb_top
